/* File: inc/nvm_pkg.sv */
// Purpose: Shared constants and types of the nonvolatile save/restore block
// Assumes: Register offsets are byte addresses of the serial control port
// Notes:   Script opcode codes and the default script layout are defined here
package nvm_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register map
   localparam logic [11:0] SCRIPT_BASE  = 12'ha00;
   localparam logic [11:0] SCRIPT_LAST  = 12'haff;
   localparam logic [11:0] STATUS_OFS   = 12'hb00;
   localparam logic [11:0] ERROR_OFS    = 12'hb01;
   localparam logic [11:0] CONTROL_OFS  = 12'hb02;
   localparam logic [11:0] SAVE_OFS     = 12'hb03;

   // Field positions
   localparam int STATUS_BIT = 0;
   localparam int ERROR_BIT  = 0;
   localparam int WEN_BIT    = 0;
   localparam int RELOAD_BIT = 1;
   localparam int SAVE_BIT   = 0;
   localparam int KIND_BIT   = 7;

   // Reset values
   localparam logic WEN_RESET    = 1'b0;
   localparam logic RELOAD_RESET = 1'b0;
   localparam logic SAVE_RESET   = 1'b0;

   // Script opcodes
   localparam logic [7:0] OP_APPLY = 8'h80;
   localparam logic [7:0] OP_END   = 8'hff;

   // Widths
   localparam int NVM_AW = 11;

   ////////////////////////////////////////////////////////////////////////
   // Timing: idle gap after a transfer
   localparam int CLK_PERIOD_NS = 50;
   localparam int XFER_GAP_NS   = 10000;
   localparam int XFER_GAP_CYC  =
      (XFER_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////
   // Default script: four 128-byte blocks, then apply, then end
   function automatic logic [7:0] default_script(input logic [7:0] idx);
      logic [7:0] b;
      b = OP_END;
      case (idx)
         8'h00, 8'h03, 8'h06, 8'h09: b = 8'h7f;
         8'h01, 8'h02, 8'h04, 8'h08: b = 8'h00;
         8'h05, 8'h0b:               b = 8'h80;
         8'h07, 8'h0a:               b = 8'h01;
         8'h0c:                      b = OP_APPLY;
         default:                    b = OP_END;
      endcase
      return b;
   endfunction

   typedef enum {w_idle, w_reset, w_cmd, w_addr_hi, w_addr_lo, w_move}
      walk_e;
   typedef enum {m_idle, m_src, m_cap, m_dst, m_wr} mover_e;

endpackage

/* File: inc/mover_if.sv */
// Purpose: Link between the script walker and the byte mover
// Assumes: Both ends on clk_sys
// Notes:   start is a one-cycle pulse; done a one-cycle pulse with err
`timescale 1ns/1ps
interface mover_if #(parameter int NVM_AW = nvm_pkg::NVM_AW);
   logic        start;
   logic        rewind;
   logic        save;
   logic [15:0] reg_addr;
   logic [6:0]  len_m1;
   logic        done;
   logic        err;

   modport walker (output start, rewind, save, reg_addr, len_m1,
                   input  done, err);
   modport mover  (input  start, rewind, save, reg_addr, len_m1,
                   output done, err);
endinterface

/* File: rtl/nvm_byte_mover.sv */
// Purpose: Moves one script entry byte by byte between buffer bank and NVM
// Assumes: Buffer read data stands while buf_rd is high; NVM ack a pulse
// Notes:   NVM address runs on across entries until rewound
`timescale 1ns/1ps
module nvm_byte_mover #(
   parameter int NVM_AW = nvm_pkg::NVM_AW
) (
   input  wire logic              clk_sys,
   input  wire logic              rst_b,
   mover_if.mover                 mv,
   input  wire logic [7:0]        buf_rdata,
   input  wire logic              nvm_ack,
   input  wire logic [7:0]        nvm_rdata,
   input  wire logic              nvm_bad,
   output logic                   buf_rd,
   output logic                   buf_we,
   output logic [15:0]            buf_addr,
   output logic [7:0]             buf_wdata,
   output logic                   nvm_req,
   output logic                   nvm_we,
   output logic [NVM_AW-1:0]      nvm_addr,
   output logic [7:0]             nvm_wdata
);
   typedef struct packed {
      nvm_pkg::mover_e   st;
      logic              save;
      logic [15:0]       raddr;
      logic [6:0]        left;
      logic [NVM_AW-1:0] naddr;
      logic [7:0]        data;
      logic              err;
      logic              done;
      logic              nvm_req;
      logic              nvm_we;
      logic              buf_rd;
      logic              buf_we;
   } mover_s;

   mover_s q;
   mover_s n;

   always_comb begin
      n = q;
      n.done = 1'b0;
      unique case (q.st)
         nvm_pkg::m_idle: begin
            if (mv.start) begin
               n.save  = mv.save;
               n.raddr = mv.reg_addr;
               n.left  = mv.len_m1;
               n.err   = 1'b0;
               if (mv.rewind) begin
                  n.naddr = '0;
               end
               if (mv.save) begin
                  n.buf_rd = 1'b1;
                  n.st     = nvm_pkg::m_cap;
               end else begin
                  n.nvm_req = 1'b1;
                  n.nvm_we  = 1'b0;
                  n.st      = nvm_pkg::m_src;
               end
            end
         end
         nvm_pkg::m_cap: begin
            n.buf_rd  = 1'b0;
            n.data    = buf_rdata;
            n.nvm_req = 1'b1;
            n.nvm_we  = 1'b1;
            n.st      = nvm_pkg::m_dst;
         end
         nvm_pkg::m_src: begin
            if (nvm_ack) begin
               n.nvm_req = 1'b0;
               n.data    = nvm_rdata;
               n.err     = q.err | nvm_bad;
               n.buf_we  = 1'b1;
               n.st      = nvm_pkg::m_wr;
            end
         end
         nvm_pkg::m_dst, nvm_pkg::m_wr: begin
            // Byte finished once the destination took it
            if (q.st == nvm_pkg::m_wr || nvm_ack) begin
               n.nvm_req = 1'b0;
               n.nvm_we  = 1'b0;
               n.buf_we  = 1'b0;
               n.naddr   = q.naddr + 1'b1;
               n.raddr   = q.raddr + 16'h0001;
               if (q.left == 7'h00) begin
                  n.done = 1'b1;
                  n.st   = nvm_pkg::m_idle;
               end else begin
                  n.left = q.left - 7'h01;
                  if (q.save) begin
                     n.buf_rd = 1'b1;
                     n.st     = nvm_pkg::m_cap;
                  end else begin
                     n.nvm_req = 1'b1;
                     n.st      = nvm_pkg::m_src;
                  end
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         q <= '{st: nvm_pkg::m_idle, default: '0};
      end else begin
         q <= n;
      end
   end

   assign mv.done   = q.done;
   assign mv.err    = q.err;
   assign buf_rd    = q.buf_rd;
   assign buf_we    = q.buf_we;
   assign buf_addr  = q.raddr;
   assign buf_wdata = q.data;
   assign nvm_req   = q.nvm_req;
   assign nvm_we    = q.nvm_we;
   assign nvm_addr  = q.naddr;
   assign nvm_wdata = q.data;
endmodule

/* File: rtl/nvm_register_save_restore.sv */
// Purpose: Script-driven save and restore of buffer registers to NVM
// Assumes: Register strobes come from serial port logic on clk_sys
// Notes:   Boot-select pin is asynchronous and is synchronised here
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
module nvm_register_save_restore #(
   parameter int NVM_AW = nvm_pkg::NVM_AW
) (
   input  wire logic              clk_sys,
   input  wire logic              rst_b,

   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire logic [11:0]       reg_addr,
   input  wire logic [7:0]        reg_wdata,
   output logic [7:0]             reg_rdata,

   input  wire logic              status_on_pin,
   input  wire logic              boot_sel_pin,
   output logic                   status_pin,
   output logic                   apply_update,
   output logic                   soft_reset,

   input  wire logic [7:0]        buf_rdata,
   output logic                   buf_rd,
   output logic                   buf_we,
   output logic [15:0]            buf_addr,
   output logic [7:0]             buf_wdata,

   input  wire logic              nvm_ack,
   input  wire logic [7:0]        nvm_rdata,
   input  wire logic              nvm_bad,
   output logic                   nvm_req,
   output logic                   nvm_we,
   output logic [NVM_AW-1:0]      nvm_addr,
   output logic [7:0]             nvm_wdata
);
   // Wide enough to hold the full idle count
   localparam int GAP_W = $clog2(nvm_pkg::XFER_GAP_CYC + 1);

   typedef struct packed {
      // Script walk
      nvm_pkg::walk_e    st;
      logic [7:0]        ptr;
      logic              save;
      logic [6:0]        len_m1;
      logic [7:0]        hi;
      logic [15:0]       addr;

      // Transfer state
      logic              start;
      logic              first;
      logic              busy;
      logic              err;

      // Software controls
      logic              wen;
      logic              reload;
      logic              save_req;

      // Registered outputs
      logic              apply;
      logic              dev_reset;
      logic              status_pin;
      logic [7:0]        rdata;

      // Pin sync and idle gap
      logic [1:0]        boot_sync;
      logic [GAP_W-1:0]  gap;
   } ctrl_s;

   ctrl_s      q;
   ctrl_s      n;
   logic [7:0] script_q [0:255];
   logic [7:0] cur;
   logic       finish;
   logic       hit_script;

   // Walker and mover meet only through this link
   mover_if #(.NVM_AW(NVM_AW)) mv ();

   ////////////////////////////////////////////////////////////////////////
   // Script store
   assign hit_script = (reg_addr >= nvm_pkg::SCRIPT_BASE) &&
                       (reg_addr <= nvm_pkg::SCRIPT_LAST);
   assign cur        = script_q[q.ptr];

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         // Reset brings back the default script
         for (int i = 0; i < 256; i++) begin
            script_q[i] <= nvm_pkg::default_script(8'(i));
         end
      end else if (reg_wr && hit_script) begin
         script_q[reg_addr[7:0]] <= reg_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Script walker
   always_comb begin
      n        = q;
      finish   = 1'b0;
      n.start  = 1'b0;
      n.apply  = 1'b0;
      n.dev_reset = 1'b0;
      n.boot_sync = {q.boot_sync[0], boot_sel_pin};

      // Idle gap runs down after every finish
      if (q.gap != '0) begin
         n.gap = q.gap - 1'b1;
      end

      unique case (q.st)
         nvm_pkg::w_idle: begin
            // Starts wait out the post-transfer gap
            if (q.gap == '0 && q.save_req) begin
               n.busy  = 1'b1;
               n.save  = 1'b1;
               n.first = 1'b1;
               n.ptr   = 8'h00;
               n.err   = 1'b0;
               n.st    = nvm_pkg::w_cmd;
            end else if (q.gap == '0 && q.reload) begin
               n.busy      = 1'b1;
               n.save      = 1'b0;
               n.first     = 1'b1;
               n.ptr       = 8'h00;
               n.err       = 1'b0;
               n.dev_reset = 1'b1;
               n.st        = nvm_pkg::w_reset;
            end
         end

         nvm_pkg::w_reset: begin
            n.st = nvm_pkg::w_cmd;
         end

         nvm_pkg::w_cmd: begin
            if (!cur[nvm_pkg::KIND_BIT]) begin
               n.len_m1 = cur[6:0];
               if (q.ptr > 8'hfd) begin
                  // No room for the address bytes: stop safely
                  finish = 1'b1;
               end else begin
                  n.ptr = q.ptr + 8'h01;
                  n.st  = nvm_pkg::w_addr_hi;
               end
            end else if (cur == nvm_pkg::OP_APPLY) begin
               n.apply = 1'b1;
               if (q.ptr == 8'hff) begin
                  finish = 1'b1;
               end else begin
                  n.ptr = q.ptr + 8'h01;
               end
            end else begin
               // Any other opcode is treated as end of data
               finish = 1'b1;
            end
         end

         nvm_pkg::w_addr_hi: begin
            n.hi  = cur;
            n.ptr = q.ptr + 8'h01;
            n.st  = nvm_pkg::w_addr_lo;
         end

         nvm_pkg::w_addr_lo: begin
            n.addr  = {q.hi, cur};
            n.ptr   = q.ptr + 8'h01;
            // One-cycle launch of the entry
            n.start = 1'b1;
            n.st    = nvm_pkg::w_move;
         end

         nvm_pkg::w_move: begin
            // Wait for the mover to finish the entry
            if (mv.done) begin
               n.first = 1'b0;
               n.err   = q.err | mv.err;
               if (q.ptr == 8'h00) begin
                  // Pointer wrapped: script had no end opcode
                  finish = 1'b1;
               end else begin
                  n.st = nvm_pkg::w_cmd;
               end
            end
         end
      endcase

      // Pending start bits clear here; save_req also clears on a save write while wen is low
      if (finish) begin
         n.busy     = 1'b0;
         n.save_req = 1'b0;
         n.reload   = 1'b0;
         n.gap      = GAP_W'(nvm_pkg::XFER_GAP_CYC);
         n.st       = nvm_pkg::w_idle;
      end

      ////////////////////////////////////////////////////////////////////
      // Register writes
      if (reg_wr && reg_addr == nvm_pkg::CONTROL_OFS) begin
         n.wen = reg_wdata[nvm_pkg::WEN_BIT];
         // Boot pin used only after its second flop
         if (reg_wdata[nvm_pkg::RELOAD_BIT] && !q.boot_sync[1] &&
             !q.busy) begin
            n.reload = 1'b1;
         end
      end

      if (reg_wr && reg_addr == nvm_pkg::SAVE_OFS &&
          reg_wdata[nvm_pkg::SAVE_BIT] && !q.busy) begin
         // Write protection drops the request silently
         n.save_req = q.wen;
      end

      ////////////////////////////////////////////////////////////////////
      // Register reads and status pin
      n.status_pin = n.busy & status_on_pin;

      // Read data holds until the next read
      if (reg_rd) begin
         n.rdata = 8'h00;
         if (hit_script) begin
            n.rdata = script_q[reg_addr[7:0]];
         end else if (reg_addr == nvm_pkg::STATUS_OFS) begin
            n.rdata[nvm_pkg::STATUS_BIT] = q.busy;
         end else if (reg_addr == nvm_pkg::ERROR_OFS) begin
            n.rdata[nvm_pkg::ERROR_BIT] = q.err;
         end else if (reg_addr == nvm_pkg::CONTROL_OFS) begin
            n.rdata[nvm_pkg::WEN_BIT]    = q.wen;
            n.rdata[nvm_pkg::RELOAD_BIT] = q.reload;
         end else if (reg_addr == nvm_pkg::SAVE_OFS) begin
            n.rdata[nvm_pkg::SAVE_BIT] = q.save_req;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         q          <= '{st: nvm_pkg::w_idle, default: '0};
         q.wen      <= nvm_pkg::WEN_RESET;
         q.reload   <= nvm_pkg::RELOAD_RESET;
         q.save_req <= nvm_pkg::SAVE_RESET;
      end else begin
         q <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Byte mover
   assign mv.start    = q.start;
   assign mv.rewind   = q.first;
   assign mv.save     = q.save;
   assign mv.reg_addr = q.addr;
   assign mv.len_m1   = q.len_m1;

   nvm_byte_mover #(.NVM_AW(NVM_AW)) u_mover (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .mv        (mv.mover),
      .buf_rdata (buf_rdata),
      .nvm_ack   (nvm_ack),
      .nvm_rdata (nvm_rdata),
      .nvm_bad   (nvm_bad),
      .buf_rd    (buf_rd),
      .buf_we    (buf_we),
      .buf_addr  (buf_addr),
      .buf_wdata (buf_wdata),
      .nvm_req   (nvm_req),
      .nvm_we    (nvm_we),
      .nvm_addr  (nvm_addr),
      .nvm_wdata (nvm_wdata)
   );

   // Every output comes straight from a flop
   assign reg_rdata    = q.rdata;
   assign status_pin   = q.status_pin;
   assign apply_update = q.apply;
   assign soft_reset   = q.dev_reset;

endmodule

/* File: verification/nvm_register_save_restore_chk.sv */
// Purpose: Port assertions of the save/restore block
// Assumes: One clock; write enable tracked from register writes
// Notes:   Bound to the top module
`timescale 1ns/1ps
module nvm_register_save_restore_chk #(
   parameter int NVM_AW = nvm_pkg::NVM_AW
) (
   input wire logic              clk_sys,
   input wire logic              rst_b,
   input wire logic              reg_wr,
   input wire logic [11:0]       reg_addr,
   input wire logic [7:0]        reg_wdata,
   input wire logic              status_on_pin,
   input wire logic              boot_sel_pin,
   input wire logic              status_pin,
   input wire logic              apply_update,
   input wire logic              soft_reset,
   input wire logic              buf_we,
   input wire logic [7:0]        buf_wdata,
   input wire logic              nvm_ack,
   input wire logic [7:0]        nvm_rdata,
   input wire logic              nvm_bad,
   input wire logic              nvm_req,
   input wire logic              nvm_we,
   input wire logic [NVM_AW-1:0] nvm_addr
);
   logic              wen_q;
   logic [NVM_AW-1:0] last_q;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   ///////////////////////////////////////////////////////////////////////
   // Helpers
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         wen_q  <= 1'b0;
         last_q <= '0;
      end else begin
         if (reg_wr && reg_addr == nvm_pkg::CONTROL_OFS) begin
            wen_q <= reg_wdata[nvm_pkg::WEN_BIT];
         end
         if (nvm_req && nvm_ack) begin
            last_q <= nvm_addr;
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // Assertions
   status_gate_a: assert property (
      !status_on_pin && $past(!status_on_pin) |-> !status_pin)
      else $error("status pin high while unselected");
   busy_pin_a: assert property (
      nvm_req && $past(status_on_pin) |-> status_pin)
      else $error("memory traffic without busy");
   write_protect_a: assert property (
      nvm_req && nvm_we |-> wen_q)
      else $error("memory write while protected");
   req_hold_a: assert property (
      nvm_req && !nvm_ack |=> nvm_req && $stable(nvm_addr) && $stable(nvm_we))
      else $error("memory request changed before ack");
   read_store_a: assert property (
      nvm_req && nvm_ack && !nvm_we |=>
         buf_we && buf_wdata == $past(nvm_rdata))
      else $error("restored byte not stored");
   apply_pulse_a: assert property (
      apply_update |=> !apply_update)
      else $error("apply not self clearing");
   reload_boot_a: assert property (
      $rose(soft_reset) |-> !$past(boot_sel_pin, 4))
      else $error("reload with boot select high");
   addr_step_a: assert property (
      $rose(nvm_req) |-> nvm_addr == '0 || nvm_addr == last_q + 1'b1)
      else $error("memory address out of order");

   cover property (soft_reset);
   cover property (apply_update);
   cover property (nvm_ack && nvm_bad);
endmodule

bind nvm_register_save_restore nvm_register_save_restore_chk #(
   .NVM_AW(NVM_AW)
) i_chk (
   .clk_sys(clk_sys), .rst_b(rst_b), .reg_wr(reg_wr),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .status_on_pin(status_on_pin), .boot_sel_pin(boot_sel_pin),
   .status_pin(status_pin), .apply_update(apply_update),
   .soft_reset(soft_reset), .buf_we(buf_we), .buf_wdata(buf_wdata),
   .nvm_ack(nvm_ack), .nvm_rdata(nvm_rdata), .nvm_bad(nvm_bad),
   .nvm_req(nvm_req), .nvm_we(nvm_we), .nvm_addr(nvm_addr)
);

/* File: verification/nvm_far_model.sv */
// Purpose: Buffer bank and nonvolatile memory behind the block
// Assumes: Ack delay and bad data are set by the bench
// Notes:   Idle data lines toggle so stale values never match
`timescale 1ns/1ps
module nvm_far_model #(
   parameter int NVM_AW = nvm_pkg::NVM_AW
) (
   input  wire logic              clk_sys,
   input  wire logic              buf_rd,
   input  wire logic              buf_we,
   input  wire logic [15:0]       buf_addr,
   input  wire logic [7:0]        buf_wdata,
   output logic [7:0]             buf_rdata,
   input  wire logic              nvm_req,
   input  wire logic              nvm_we,
   input  wire logic [NVM_AW-1:0] nvm_addr,
   input  wire logic [7:0]        nvm_wdata,
   output logic                   nvm_ack,
   output logic [7:0]             nvm_rdata,
   output logic                   nvm_bad,
   input  wire logic [1:0]        ack_wait,
   input  wire logic              bad_en
);
   logic [7:0] buf_mem [0:65535];
   logic [7:0] nvm_mem [0:2**NVM_AW-1];
   int         cnt = 0;

   initial begin
      buf_rdata = 8'h00;
      nvm_ack = 1'b0;
      nvm_rdata = 8'h00;
      nvm_bad = 1'b0;
   end

   // Read data stands while buf_rd is still high
   always @(negedge clk_sys) begin
      buf_rdata <= buf_rd ? buf_mem[buf_addr] : ~buf_rdata;
   end

   always @(posedge clk_sys) begin
      if (buf_we) buf_mem[buf_addr] <= buf_wdata;
      nvm_ack <= 1'b0;
      nvm_bad <= 1'b0;
      nvm_rdata <= ~nvm_rdata;
      if (nvm_req && !nvm_ack) begin
         if (cnt >= ack_wait) begin
            cnt = 0;
            nvm_ack <= 1'b1;
            nvm_bad <= bad_en;
            nvm_rdata <= nvm_mem[nvm_addr];
            if (nvm_we) nvm_mem[nvm_addr] <= nvm_wdata;
         end else begin
            cnt++;
         end
      end
   end
endmodule

/* File: verification/nvm_register_save_restore_test.sv */
// Purpose: Self-checking bench of the save/restore block
// Assumes: Register strobes driven on the falling edge
// Notes:   Script walk model predicts buffer and memory contents
`timescale 1ns/1ps
module nvm_register_save_restore_test;
   logic        clk_sys, rst_b, reg_wr, reg_rd, status_on_pin;
   logic        boot_sel_pin, status_pin, apply_update, soft_reset;
   logic        buf_rd, buf_we, nvm_ack, nvm_bad, nvm_req, nvm_we, bad_en;
   logic [11:0] reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, buf_rdata, buf_wdata;
   logic [7:0]  nvm_rdata, nvm_wdata, d;
   logic [15:0] buf_addr;
   logic [1:0]  ack_wait;
   logic [nvm_pkg::NVM_AW-1:0] nvm_addr;
   logic [7:0]  scr [0:255];
   logic [7:0]  eb [0:65535];
   logic [7:0]  en [0:2**nvm_pkg::NVM_AW-1];
   int          errors = 0;
   int          check_count = 0;
   int          n_apply = 0;
   int          n_rst = 0;
   int          n_wr = 0;
   int          x_apply = 0;
   int          seed, i;

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   nvm_register_save_restore i_dut (
      .clk_sys(clk_sys), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .status_on_pin(status_on_pin), .boot_sel_pin(boot_sel_pin),
      .status_pin(status_pin), .apply_update(apply_update),
      .soft_reset(soft_reset), .buf_rdata(buf_rdata), .buf_rd(buf_rd),
      .buf_we(buf_we), .buf_addr(buf_addr), .buf_wdata(buf_wdata),
      .nvm_ack(nvm_ack), .nvm_rdata(nvm_rdata), .nvm_bad(nvm_bad),
      .nvm_req(nvm_req), .nvm_we(nvm_we), .nvm_addr(nvm_addr),
      .nvm_wdata(nvm_wdata));

   nvm_far_model i_far (
      .clk_sys(clk_sys), .buf_rd(buf_rd), .buf_we(buf_we),
      .buf_addr(buf_addr), .buf_wdata(buf_wdata), .buf_rdata(buf_rdata),
      .nvm_req(nvm_req), .nvm_we(nvm_we), .nvm_addr(nvm_addr),
      .nvm_wdata(nvm_wdata), .nvm_ack(nvm_ack), .nvm_rdata(nvm_rdata),
      .nvm_bad(nvm_bad), .ack_wait(ack_wait), .bad_en(bad_en));

   always @(posedge clk_sys) begin
      if (rst_b === 1'b1) begin
         if (apply_update === 1'b1) n_apply++;
         if (soft_reset === 1'b1) n_rst++;
         if (nvm_req === 1'b1 && nvm_we === 1'b1 && nvm_ack === 1'b1) n_wr++;
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // Tasks
   task report_and_stop;
      if (errors == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task chk(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task wr(input logic [11:0] a, input logic [7:0] v);
      @(negedge clk_sys);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = v;
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask

   task rd(input logic [11:0] a, output logic [7:0] v);
      @(negedge clk_sys);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      v = reg_rdata;
   endtask

   // Busy may wait out the idle gap before it rises
   task wait_done;
      int k, m;
      for (k = 0; k < 600 && status_pin !== 1'b1; k++) @(negedge clk_sys);
      for (m = 0; m < 20000 && status_pin !== 1'b0; m++) @(negedge clk_sys);
      if (k == 600 || status_pin !== 1'b0) begin
         errors++;
         $display("mismatch at %0t: transfer hung", $time);
         report_and_stop;
      end
   endtask

   task fill;
      int k;
      for (k = 0; k < 512; k++) begin
         eb[k] = 8'($random(seed));
         i_far.buf_mem[k] = eb[k];
      end
      ack_wait = 2'($random(seed));
   endtask

   task automatic walk(input bit save);
      int p, k, a, na;
      p = 0;
      na = 0;
      while (p < 256) begin
         if (scr[p][7]) begin
            if (scr[p] != 8'h80) break;
            x_apply++;
            p++;
         end else begin
            if (p > 253) break;
            a = {scr[p+1], scr[p+2]};
            for (k = 0; k <= int'(scr[p][6:0]); k++) begin
               if (save) en[na] = eb[a+k];
               else eb[a+k] = en[na];
               na++;
            end
            p += 3;
         end
      end
   endtask

   task cmp_mem;
      int k;
      for (k = 0; k < 512; k++) begin
         chk(i_far.nvm_mem[k], en[k]);
         chk(i_far.buf_mem[k], eb[k]);
      end
      chk(8'(n_apply), 8'(x_apply));
   endtask

   // Keeps the idle time between transfers
   task gap;
      repeat (nvm_pkg::XFER_GAP_CYC + 10) @(negedge clk_sys);
   endtask

   ///////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      seed = 8078;
      rst_b = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 12'h000;
      reg_wdata = 8'h00;
      status_on_pin = 1'b0;
      boot_sel_pin = 1'b0;
      bad_en = 1'b0;
      ack_wait = 2'h0;
      for (i = 0; i < 256; i++) scr[i] = 8'hff;
      for (i = 0; i < 4; i++) begin
         scr[3*i] = 8'h7f;
         scr[3*i+1] = 8'(i / 2);
         scr[3*i+2] = (i % 2) ? 8'h80 : 8'h00;
      end
      scr[12] = 8'h80;
      for (i = 0; i < 2**nvm_pkg::NVM_AW; i++) begin
         en[i] = 8'h00;
         i_far.nvm_mem[i] = 8'h00;
      end
      fill;
      repeat (5) @(negedge clk_sys);
      rst_b = 1'b1;
      rd(nvm_pkg::CONTROL_OFS, d); chk(d, 8'h00);
      rd(nvm_pkg::STATUS_OFS, d); chk(d, 8'h00);
      for (i = 0; i < 16; i++) begin
         rd(12'ha00 + 12'(i), d); chk(d, scr[i]);
      end
      rd(12'haff, d); chk(d, 8'hff);
      wr(nvm_pkg::ERROR_OFS, 8'hff);
      rd(nvm_pkg::ERROR_OFS, d); chk(d, 8'h00);
      rd(12'hc00, d); chk(d, 8'h00);
      wr(nvm_pkg::SAVE_OFS, 8'h01);
      repeat (20) @(negedge clk_sys);
      rd(nvm_pkg::SAVE_OFS, d); chk(d, 8'h00);
      chk(8'(n_wr), 8'h00);
      status_on_pin = 1'b1;
      wr(nvm_pkg::CONTROL_OFS, 8'h01);
      wr(nvm_pkg::SAVE_OFS, 8'h01);
      rd(nvm_pkg::SAVE_OFS, d); chk(d, 8'h01);
      wait_done;
      walk(1'b1);
      rd(nvm_pkg::SAVE_OFS, d); chk(d, 8'h00);
      cmp_mem;
      gap;
      fill;
      scr[0] = 8'h01;
      scr[1] = 8'h00;
      scr[2] = 8'h10;
      scr[4] = 8'h01;
      scr[5] = 8'h00;
      scr[6] = 8'h80;
      scr[7] = 8'hff;
      for (i = 0; i < 8; i++) wr(12'ha00 + 12'(i), scr[i]);
      wr(nvm_pkg::SAVE_OFS, 8'h01);
      wait_done;
      walk(1'b1);
      cmp_mem;
      gap;
      fill;
      bad_en = 1'b1;
      wr(nvm_pkg::CONTROL_OFS, 8'h03);
      wait_done;
      walk(1'b0);
      cmp_mem;
      chk(8'(n_rst), 8'h01);
      rd(nvm_pkg::ERROR_OFS, d); chk(d, 8'h01);
      rd(nvm_pkg::CONTROL_OFS, d); chk(d, 8'h01);
      gap;
      bad_en = 1'b0;
      boot_sel_pin = 1'b1;
      repeat (10) @(negedge clk_sys);
      wr(nvm_pkg::CONTROL_OFS, 8'h03);
      repeat (20) @(negedge clk_sys);
      chk(8'(n_rst), 8'h01);
      rd(nvm_pkg::STATUS_OFS, d); chk(d, 8'h00);
      boot_sel_pin = 1'b0;
      gap;
      scr[0] = 8'hff;
      wr(12'ha00, 8'hff);
      wr(nvm_pkg::SAVE_OFS, 8'h01);
      wait_done;
      walk(1'b1);
      cmp_mem;
      rd(nvm_pkg::ERROR_OFS, d); chk(d, 8'h00);
      report_and_stop;
   end
endmodule
